// ### rtc_alarm_defines.svh
// register offsets, field positions and reset values of the calendar and alarm block
`ifndef RTC_ALARM_DEFINES_SVH
`define RTC_ALARM_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define OFS_CAL_MONTH    8'h0d
`define OFS_CAL_YEAR     8'h0e
`define OFS_ALARM_SECOND 8'h10
`define OFS_ALARM_MINUTE 8'h11
`define OFS_ALARM_HOUR   8'h12
`define OFS_ALARM_DAY    8'h13

// ------------------------------------------------------------
// field positions and masks
// ------------------------------------------------------------
`define MATCH_EN_BIT     7
`define HOUR_FMT_BIT     6
`define MONTH_MASK       8'h1f
`define YEAR_MASK        8'h7f
`define SECMIN_MASK      8'h7f
`define HOUR_MASK        8'h3f
`define DAY_MASK         8'h3f
`define ALARM_SM_WMASK   8'hff
`define ALARM_HD_WMASK   8'hbf
`define LEAP_MASK        8'h13

// ------------------------------------------------------------
// calendar constants and reset values
// ------------------------------------------------------------
`define MONTH_FIRST      8'h01
`define MONTH_LAST       8'h12
`define MONTH_FEB        8'h02
`define MONTH_APR        8'h04
`define MONTH_JUN        8'h06
`define MONTH_SEP        8'h09
`define MONTH_NOV        8'h11
`define YEAR_FIRST       8'h00
`define YEAR_LAST        8'h79
`define DAYS_28          8'h28
`define DAYS_29          8'h29
`define DAYS_30          8'h30
`define DAYS_31          8'h31
`define RST_MONTH        8'h01
`define RST_YEAR         8'h00
`define RST_ALARM        8'h00
`define RDATA_NONE       8'h00

`endif

// ### rtc_alarm_pkg.sv
// types shared by the calendar and alarm block
package rtc_alarm_pkg;

  // one byte-wide register of the serial register map
  typedef logic [7:0] reg_byte_type;

  // one bcd digit
  typedef logic [3:0] bcd_digit_type;

endpackage

// ### calendar_alarm.sv
// month and year calendar registers with alarm comparison and alarm flag
`include "rtc_alarm_defines.svh"

module calendar_alarm (
  // clock, reset and enable
  input  wire logic                        ref_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        ce_i,
  // register port behind the serial interface
  input  wire logic [7:0]                  reg_addr_i,
  input  wire logic                        reg_wr_i,
  input  wire logic [7:0]                  reg_wdata_i,
  output logic      [7:0]                  reg_rdata_o,
  // running time from the timekeeping counters
  input  wire logic [7:0]                  time_second_i,
  input  wire logic [7:0]                  time_minute_i,
  input  wire logic [7:0]                  time_hour_i,
  input  wire logic [7:0]                  time_day_i,
  input  wire logic                        month_carry_i,
  // calendar results
  output logic      [7:0]                  month_o,
  output logic      [7:0]                  year_o,
  output logic      [7:0]                  month_days_o,
  // alarm control and status
  input  wire logic                        alarm_irq_enable_i,
  input  wire logic                        alarm_flag_clear_i,
  output logic                             alarm_flag_o,
  output logic                             int_n_o
);

  // ------------------------------------------------------------
  // bcd increment helper
  // ------------------------------------------------------------

  // adds one to a two-digit bcd byte, carrying into the tens digit
  function automatic rtc_alarm_pkg::reg_byte_type bcd_inc(input rtc_alarm_pkg::reg_byte_type v);
    rtc_alarm_pkg::bcd_digit_type tens;
    rtc_alarm_pkg::bcd_digit_type ones;
    tens = v[7:4];
    ones = v[3:0];
    if (ones == 4'h9) begin
      bcd_inc = {4'(tens + 4'h1), 4'h0};
    end else begin
      bcd_inc = {tens, 4'(ones + 4'h1)};
    end
  endfunction

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  rtc_alarm_pkg::reg_byte_type month_r,   month_nxt;     // calendar month
  rtc_alarm_pkg::reg_byte_type year_r,    year_nxt;      // calendar year
  rtc_alarm_pkg::reg_byte_type al_sec_r,  al_sec_nxt;    // second alarm
  rtc_alarm_pkg::reg_byte_type al_min_r,  al_min_nxt;    // minute alarm
  rtc_alarm_pkg::reg_byte_type al_hour_r, al_hour_nxt;   // hour alarm
  rtc_alarm_pkg::reg_byte_type al_day_r,  al_day_nxt;    // day alarm
  rtc_alarm_pkg::reg_byte_type rdata_r,   rdata_nxt;     // read data
  rtc_alarm_pkg::reg_byte_type mdays_r,   mdays_nxt;     // days in month
  logic                        match_prev_r, match_prev_nxt; // last match
  logic                        flag_r,       flag_nxt;       // alarm flag
  logic                        int_n_r,      int_n_nxt;      // interrupt pin

  // ------------------------------------------------------------
  // alarm comparison
  // ------------------------------------------------------------
  logic second_match_enable;    // enable bits of each field
  logic minute_match_enable;
  logic hour_match_enable;
  logic day_match_enable;
  logic hour_12_mode;           // hour format bit of the running time
  logic match_all;              // all enabled fields agree
  logic alarm_event;            // first cycle of a match
  logic leap_year;              // february gets 29 days

  assign second_match_enable = al_sec_r[`MATCH_EN_BIT];
  assign minute_match_enable = al_min_r[`MATCH_EN_BIT];
  assign hour_match_enable   = al_hour_r[`MATCH_EN_BIT];
  assign day_match_enable    = al_day_r[`MATCH_EN_BIT];
  assign hour_12_mode        = time_hour_i[`HOUR_FMT_BIT];

  // each field passes when disabled or when equal; at least one must be enabled
  always_comb begin
    logic sec_ok;
    logic min_ok;
    logic hour_ok;
    logic day_ok;
    // default pass, narrowed by the format branches below
    hour_ok = 1'b1;
    sec_ok  = !second_match_enable ||
              ((al_sec_r & `SECMIN_MASK) == (time_second_i & `SECMIN_MASK));
    min_ok  = !minute_match_enable ||
              ((al_min_r & `SECMIN_MASK) == (time_minute_i & `SECMIN_MASK));
    // in 12-hour mode bit 5 is the pm flag and bits 4-0 the hour; in 24-hour mode
    // bits 5-0 are the hour, so one six-bit compare covers both formats
    if (hour_12_mode) begin
      hour_ok = !hour_match_enable ||
                ((al_hour_r & `HOUR_MASK) == (time_hour_i & `HOUR_MASK));
    end else begin
      hour_ok = !hour_match_enable ||
                ((al_hour_r & `HOUR_MASK) == (time_hour_i & `HOUR_MASK));
    end
    day_ok  = !day_match_enable ||
              ((al_day_r & `DAY_MASK) == (time_day_i & `DAY_MASK));
    // wired and of all fields; with nothing enabled no alarm fires
    match_all = sec_ok && min_ok && hour_ok && day_ok &&
                (second_match_enable || minute_match_enable ||
                 hour_match_enable || day_match_enable);
  end

  assign alarm_event = match_all && !match_prev_r;

  // leap year when the bcd year is a multiple of four, year 00 included
  assign leap_year = ((year_r[4] ? 8'h02 : 8'h00) + {6'h00, year_r[1:0]}) == 8'h00 ||
                     ((year_r[4] ? 8'h02 : 8'h00) + {6'h00, year_r[1:0]}) == 8'h04;

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------

  // host writes, month advance, read mux, days of month and alarm flag
  always_comb begin
    month_nxt      = month_r;
    year_nxt       = year_r;
    al_sec_nxt     = al_sec_r;
    al_min_nxt     = al_min_r;
    al_hour_nxt    = al_hour_r;
    al_day_nxt     = al_day_r;
    rdata_nxt      = `RDATA_NONE;
    mdays_nxt      = `DAYS_31;
    match_prev_nxt = match_all;
    flag_nxt       = flag_r;
    int_n_nxt      = int_n_r;
    // calendar advance from the day counter's carry
    if (month_carry_i) begin
      if (month_r == `MONTH_LAST) begin
        month_nxt = `MONTH_FIRST;
        year_nxt  = (year_r == `YEAR_LAST) ? `YEAR_FIRST : bcd_inc(year_r);
      end else begin
        month_nxt = bcd_inc(month_r);
      end
    end
    // host writes win over the advance; unused bits stored as zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        `OFS_CAL_MONTH:    month_nxt   = reg_wdata_i & `MONTH_MASK;
        `OFS_CAL_YEAR:     year_nxt    = reg_wdata_i & `YEAR_MASK;
        `OFS_ALARM_SECOND: al_sec_nxt  = reg_wdata_i & `ALARM_SM_WMASK;
        `OFS_ALARM_MINUTE: al_min_nxt  = reg_wdata_i & `ALARM_SM_WMASK;
        `OFS_ALARM_HOUR:   al_hour_nxt = reg_wdata_i & `ALARM_HD_WMASK;
        `OFS_ALARM_DAY:    al_day_nxt  = reg_wdata_i & `ALARM_HD_WMASK;
        default:           ;  // unmapped writes are ignored
      endcase
    end
    // registered read data; unmapped addresses read zero
    case (reg_addr_i)
      `OFS_CAL_MONTH:    rdata_nxt = month_r;
      `OFS_CAL_YEAR:     rdata_nxt = year_r;
      `OFS_ALARM_SECOND: rdata_nxt = al_sec_r;
      `OFS_ALARM_MINUTE: rdata_nxt = al_min_r;
      `OFS_ALARM_HOUR:   rdata_nxt = al_hour_r;
      `OFS_ALARM_DAY:    rdata_nxt = al_day_r;
      default:           rdata_nxt = `RDATA_NONE;
    endcase
    // length of the current month for the day counter
    case (month_r)
      `MONTH_FEB: mdays_nxt = leap_year ? `DAYS_29 : `DAYS_28;
      `MONTH_APR, `MONTH_JUN, `MONTH_SEP, `MONTH_NOV: mdays_nxt = `DAYS_30;
      default:    mdays_nxt = `DAYS_31;
    endcase
    // host clear first, so an event in the same cycle still sets the flag
    if (alarm_flag_clear_i) begin
      flag_nxt = 1'b0;
    end
    if (alarm_event && alarm_irq_enable_i) begin
      flag_nxt = 1'b1;
    end
    int_n_nxt = !flag_nxt;
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------

  // synchronous reset; clock enable freezes every flop
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      month_r      <= `RST_MONTH;
      year_r       <= `RST_YEAR;
      al_sec_r     <= `RST_ALARM;
      al_min_r     <= `RST_ALARM;
      al_hour_r    <= `RST_ALARM;
      al_day_r     <= `RST_ALARM;
      rdata_r      <= `RDATA_NONE;
      mdays_r      <= `DAYS_31;
      match_prev_r <= 1'b0;
      flag_r       <= 1'b0;
      int_n_r      <= 1'b1;
    end else if (ce_i) begin
      month_r      <= month_nxt;
      year_r       <= year_nxt;
      al_sec_r     <= al_sec_nxt;
      al_min_r     <= al_min_nxt;
      al_hour_r    <= al_hour_nxt;
      al_day_r     <= al_day_nxt;
      rdata_r      <= rdata_nxt;
      mdays_r      <= mdays_nxt;
      match_prev_r <= match_prev_nxt;
      flag_r       <= flag_nxt;
      int_n_r      <= int_n_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o  = rdata_r;
  assign month_o      = month_r;
  assign year_o       = year_r;
  assign month_days_o = mdays_r;
  assign alarm_flag_o = flag_r;
  assign int_n_o      = int_n_r;

endmodule

// ### calendar_alarm_assertions.sv
// concurrent checks on the calendar and alarm block ports
module calendar_alarm_assertions (
  // clock and control
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       ce_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // calendar results
  input wire logic [7:0] month_o,
  input wire logic [7:0] year_o,
  input wire logic [7:0] month_days_o,
  // alarm
  input wire logic       alarm_irq_enable_i,
  input wire logic       alarm_flag_clear_i,
  input wire logic       alarm_flag_o,
  input wire logic       int_n_o
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic leap_year; // year count divisible by four
  always_comb leap_year = ((int'(year_o[6:4]) * 10 + int'(year_o[3:0])) % 4) == 0;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_INT_PIN: assert property (int_n_o == !alarm_flag_o)
    else $error("interrupt pin disagrees with alarm flag");
  AST_FLAG_HOLD: assert property (alarm_flag_o && !alarm_flag_clear_i |=> alarm_flag_o)
    else $error("alarm flag dropped without a clear");
  AST_FLAG_CAUSE: assert property ($rose(alarm_flag_o) |-> $past(alarm_irq_enable_i))
    else $error("alarm flag set with interrupt enable low");
  AST_MONTH_BITS: assert property (month_o[7:5] == 3'h0)
    else $error("month upper bits not zero");
  AST_YEAR_BITS: assert property (!year_o[7])
    else $error("year top bit not zero");
  AST_MONTH_WRITE: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h0d |=>
    month_o == ($past(reg_wdata_i) & 8'h1f)) else $error("month write not stored");
  AST_YEAR_WRITE: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h0e |=>
    year_o == ($past(reg_wdata_i) & 8'h7f)) else $error("year write not stored");
  AST_HOUR_READ: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h12 ##1
    ce_i && reg_addr_i == 8'h12 |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'hbf))
    else $error("hour alarm read back wrong");
  AST_LEAP_DAYS: assert property (month_o == 8'h02 && $stable(month_o) && $stable(year_o)
    |-> month_days_o == (leap_year ? 8'h29 : 8'h28)) else $error("february length wrong");

  // main scenarios reached
  cover property ($rose(alarm_flag_o));
  cover property ($fell(alarm_flag_o));
  cover property (month_days_o == 8'h29);
endmodule

bind calendar_alarm calendar_alarm_assertions u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .ce_i(ce_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .month_o(month_o), .year_o(year_o), .month_days_o(month_days_o),
  .alarm_irq_enable_i(alarm_irq_enable_i), .alarm_flag_clear_i(alarm_flag_clear_i),
  .alarm_flag_o(alarm_flag_o), .int_n_o(int_n_o));

// ### host_model.sv
// host side model that writes and reads the register port
module host_model (
  // clock
  input  wire logic       ref_clk_i,
  // register port
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one byte write, strobe up for a single edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wr_o <= 1'b1;
    reg_wdata_o <= d;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d; // released data no longer shows the byte
  endtask
  // read: address sampled at one edge, data valid after it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    @(posedge ref_clk_i);
    #1 d = reg_rdata_i;
  endtask
endmodule

// ### tb_top.sv
// testbench for the calendar registers and alarm match logic
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, month_carry_i = 1'b0;
  logic alarm_irq_enable_i = 1'b0, alarm_flag_clear_i = 1'b0;
  logic [7:0] time_second_i = 8'h00, time_minute_i = 8'h00, time_hour_i = 8'h00, time_day_i = 8'h00;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata, month, year, mdays;
  wire logic reg_wr, flag, int_n;
  int n_errors = 0, num_checks = 0;
  logic [7:0] rd;
  // register table: address, written, read back
  logic [7:0] ra[7] = '{8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h0f};
  logic [7:0] wv[7] = '{8'h25, 8'hff, 8'hd9, 8'h59, 8'hff, 8'hff, 8'hff};
  logic [7:0] ev[7] = '{8'h05, 8'h7f, 8'hd9, 8'h59, 8'hbf, 8'hbf, 8'h00};
  // february lengths per year
  logic [7:0] yv[6] = '{8'h00, 8'h04, 8'h01, 8'h76, 8'h78, 8'h12};
  logic [7:0] dv[6] = '{8'h29, 8'h29, 8'h28, 8'h29, 8'h28, 8'h29};
  // hour and day cases: alarm hour, time hour, time day, flag
  logic [7:0] ha[5] = '{8'ha1, 8'ha1, 8'ha1, 8'ha3, 8'h23};
  logic [7:0] th[5] = '{8'h61, 8'h61, 8'h41, 8'h23, 8'h07};
  logic [7:0] td[5] = '{8'h14, 8'h15, 8'h15, 8'h15, 8'h15};
  logic       xf[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #12.5 ref_clk_i = ~ref_clk_i;

  calendar_alarm DUT (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .time_second_i(time_second_i),
    .time_minute_i(time_minute_i), .time_hour_i(time_hour_i), .time_day_i(time_day_i),
    .month_carry_i(month_carry_i), .month_o(month), .year_o(year), .month_days_o(mdays),
    .alarm_irq_enable_i(alarm_irq_enable_i), .alarm_flag_clear_i(alarm_flag_clear_i),
    .alarm_flag_o(flag), .int_n_o(int_n));
  host_model HOST (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  // counts, verdict and end of run
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // let n edges pass, then let their updates land
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // running time and alarm control, applied at one edge
  task automatic drive(input logic [7:0] s, h, d, input logic ie, cl);
    @(posedge ref_clk_i);
    time_second_i <= s;
    time_hour_i <= h;
    time_day_i <= d;
    alarm_irq_enable_i <= ie;
    alarm_flag_clear_i <= cl;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    step(1);
    `CHK("month reset", 8'h01, month)
    `CHK("int pin reset", 1'b1, int_n)
    for (int i = 0; i < 7; i++) begin
      HOST.write_reg(ra[i], wv[i]);
      HOST.read_reg(ra[i], rd);
      `CHK("register", ev[i], rd)
    end
    HOST.write_reg(8'h0d, 8'h02);
    for (int i = 0; i < 6; i++) begin
      HOST.write_reg(8'h0e, yv[i]);
      step(3);
      `CHK("february days", dv[i], mdays)
    end
    HOST.write_reg(8'h0d, 8'h12);
    HOST.write_reg(8'h0e, 8'h79);
    @(posedge ref_clk_i) month_carry_i <= 1'b1;
    @(posedge ref_clk_i) month_carry_i <= 1'b0;
    #1 `CHK("year wrap", 8'h00, year)
    `CHK("month wrap", 8'h01, month)
    // seconds alarm alone; minute, hour, day disabled
    HOST.write_reg(8'h10, 8'h85);
    HOST.write_reg(8'h11, 8'h30);
    HOST.write_reg(8'h12, 8'h00);
    HOST.write_reg(8'h13, 8'h00);
    drive(8'h05, 8'h00, 8'h00, 1'b1, 1'b0);
    step(1);
    `CHK("flag on match", 1'b1, flag)
    `CHK("int pin on match", 1'b0, int_n)
    drive(8'h05, 8'h00, 8'h00, 1'b1, 1'b1);
    drive(8'h05, 8'h00, 8'h00, 1'b1, 1'b0);
    step(3);
    `CHK("flag after clear", 1'b0, flag)
    drive(8'h06, 8'h00, 8'h00, 1'b1, 1'b0);
    drive(8'h05, 8'h00, 8'h00, 1'b1, 1'b0);
    step(1);
    `CHK("flag on new match", 1'b1, flag)
    drive(8'h05, 8'h00, 8'h00, 1'b0, 1'b1);
    drive(8'h06, 8'h00, 8'h00, 1'b0, 1'b0);
    drive(8'h05, 8'h00, 8'h00, 1'b0, 1'b0);
    step(1);
    `CHK("flag with irq off", 1'b0, flag)
    // hour and day alarms, seconds disabled
    HOST.write_reg(8'h10, 8'h05);
    HOST.write_reg(8'h13, 8'h95);
    for (int i = 0; i < 5; i++) begin
      HOST.write_reg(8'h12, ha[i]);
      drive(8'h00, th[i], 8'h00, 1'b1, 1'b1);
      drive(8'h00, th[i], td[i], 1'b1, 1'b0);
      step(1);
      `CHK("hour day match", xf[i], flag)
    end
    // minute alarm together with the day alarm: one digit off, then equal
    HOST.write_reg(8'h11, 8'hb0);
    drive(8'h00, 8'h07, 8'h15, 1'b1, 1'b1);
    @(posedge ref_clk_i) alarm_flag_clear_i <= 1'b0;
    time_minute_i <= 8'h31;
    step(1);
    `CHK("minute mismatch", 1'b0, flag)
    @(posedge ref_clk_i) time_minute_i <= 8'h30;
    step(1);
    `CHK("minute match", 1'b1, flag)
    // clock enable low freezes the month despite a carry
    HOST.write_reg(8'h0d, 8'h09);
    @(posedge ref_clk_i) ce_i <= 1'b0;
    month_carry_i <= 1'b1;
    step(2);
    `CHK("month frozen", 8'h09, month)
    @(posedge ref_clk_i) ce_i <= 1'b1;
    @(posedge ref_clk_i) month_carry_i <= 1'b0;
    #1 `CHK("month bcd advance", 8'h10, month)
    // one more advance into a thirty-day month
    @(posedge ref_clk_i) month_carry_i <= 1'b1;
    @(posedge ref_clk_i) month_carry_i <= 1'b0;
    step(1);
    `CHK("month eleven", 8'h11, month)
    `CHK("thirty days", 8'h30, mdays)
    print_verdict();
  end
endmodule
